// ==== design/psc_cfg.svh ====
/*
  Constants of the programmable stage comparator: register map,
  field positions, reset values and timing counts.
  Assumes the includer sits on the 20 MHz clock.
*/
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define PSC_CLK_HZ         20000000
`define PSC_CYCLE_US       5000
`define PSC_TICK_CYCLES    ((`PSC_CYCLE_US * (`PSC_CLK_HZ / 1000000)))
`define PSC_DELTA_MS       20
`define PSC_DELTA_TICKS    ((`PSC_DELTA_MS * 1000) / `PSC_CYCLE_US)

// ****************************************
// Fixed point: one unit is 0.0001
// ****************************************
`define PSC_UNIT           64'sd10000
`define PSC_PCT_UNIT       64'sd1000000

// ****************************************
// Register map (byte addresses) and per-magnitude field indices
// ****************************************
`define PSC_A_CTRL         8'h00
`define PSC_A_OP_DLY       8'h04
`define PSC_A_REL_DLY      8'h08
`define PSC_A_STATUS       8'h0c
`define PSC_A_REMAIN       8'h10
`define PSC_A_IRQ_STAT     8'h14
`define PSC_A_IRQ_MASK     8'h18
`define PSC_A_CALC_RATIO   8'h1c
`define PSC_F_MODE         3'h0
`define PSC_F_PICK         3'h1
`define PSC_F_HYST         3'h2
`define PSC_F_MULT         3'h3
`define PSC_F_SCALED       3'h4
`define PSC_F_RATIO        3'h5

// ****************************************
// Fields and reset values
// ****************************************
`define PSC_CTRL_SEL       1:0
`define PSC_CTRL_BEH_EN    2
`define PSC_CTRL_BEH       6:4
`define PSC_RST_SEL        2'h1
`define PSC_RST_BEH        3'h1
`define PSC_RST_PICK       32'sh00000064
`define PSC_RST_HYST       32'h00007530
`define PSC_RST_MULT       32'sh00002710
`define PSC_RST_OP_DLY     16'h0008
`define PSC_RST_REL_DLY    16'h000c
`define PSC_EV_W           6

`endif

// ==== design/psc_pkg.sv ====
/*
  Types of the programmable stage comparator.
  Assumes psc_cfg.svh for the other numeric constants; the enum codes are set here.
*/
package psc_pkg;

  typedef enum logic [2:0] {
    PSC_OVER      = 3'h0,
    PSC_OVER_ABS  = 3'h1,
    PSC_UNDER     = 3'h2,
    PSC_UNDER_ABS = 3'h3,
    PSC_DREL_SGN  = 3'h4,
    PSC_DREL_ABS  = 3'h5,
    PSC_DVAL_SGN  = 3'h6,
    PSC_DVAL_ABS  = 3'h7
  } psc_mode_t;

  typedef enum logic [2:0] {
    PSC_BEH_ON      = 3'h1,
    PSC_BEH_BLOCKED = 3'h2,
    PSC_BEH_TEST    = 3'h3,
    PSC_BEH_TEST_BL = 3'h4,
    PSC_BEH_OFF     = 3'h5
  } psc_beh_t;

  typedef enum {
    PSC_ST_NORMAL,
    PSC_ST_START,
    PSC_ST_TRIP,
    PSC_ST_BLOCKED
  } psc_state_t;

endpackage

// ==== design/psc_mag_cmp.sv ====
/*
  One magnitude of the stage: scaling, ratio, comparator with
  hysteresis and 20 ms change detection.
  Assumes tick pulses once per program cycle on clk.
*/
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_mag_cmp (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              tick,
  input  wire logic signed [31:0] meas,
  input  wire logic signed [31:0] mult,
  input  wire logic signed [31:0] pick,
  input  wire logic        [31:0] hyst,
  input  wire psc_pkg::psc_mode_t mode,
  output logic signed      [31:0] scaled,
  output logic signed      [31:0] ratio,
  output logic                    hit
);
  import psc_pkg::*;

  localparam int DT = `PSC_DELTA_TICKS;

  logic signed [31:0] hist_reg [DT];
  logic [DT-1:0]      hv_reg;
  logic signed [31:0] scaled_reg, ratio_reg;
  logic               hit_reg;
  logic signed [63:0] prod, s64, p64, pabs, sabs, o64, oabs, d64, dabs;
  logic signed [63:0] band, lvl_dn, lvl_up;
  logic               hit_next;

  // ****************************************
  // Scaling and ratio
  // ****************************************
  assign prod = 64'(meas) * 64'(mult);
  assign s64  = 64'(scaled_reg);
  assign p64  = 64'(pick);
  assign pabs = p64 < 0 ? -p64 : p64;
  assign sabs = s64 < 0 ? -s64 : s64;
  assign o64  = 64'(hist_reg[DT-1]);
  assign oabs = o64 < 0 ? -o64 : o64;
  assign d64  = s64 - o64;
  assign dabs = d64 < 0 ? -d64 : d64;
  // Band is relative to the pick-up level, never to the measurement
  assign band   = (pabs * 64'(hyst)) / `PSC_PCT_UNIT;
  assign lvl_dn = hit_reg ? p64 - band : p64;
  assign lvl_up = hit_reg ? p64 + band : p64;

  // ****************************************
  // Comparator
  // ****************************************
  always_comb
  begin
    hit_next = 1'b0;
    unique case (mode)
      PSC_OVER:      hit_next = s64 > lvl_dn;
      PSC_OVER_ABS:  hit_next = sabs > lvl_dn;
      PSC_UNDER:     hit_next = s64 < lvl_up;
      PSC_UNDER_ABS: hit_next = sabs < lvl_up;
      // Relative change: pick is in percent of the older sample
      PSC_DREL_SGN:  hit_next = hv_reg[DT-1] &&
                       (p64 >= 0 ? d64 * `PSC_PCT_UNIT > p64 * oabs
                                 : d64 * `PSC_PCT_UNIT < p64 * oabs);
      PSC_DREL_ABS:  hit_next = hv_reg[DT-1] &&
                       dabs * `PSC_PCT_UNIT > pabs * oabs;
      PSC_DVAL_SGN:  hit_next = hv_reg[DT-1] &&
                       (p64 >= 0 ? d64 > p64 : d64 < p64);
      PSC_DVAL_ABS:  hit_next = hv_reg[DT-1] && dabs > pabs;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scaled_reg <= 32'sh0;
      ratio_reg  <= 32'sh0;
      hit_reg    <= 1'b0;
    end
    else if (tick)
    begin
      // Multiplier of unity leaves the raw value
      scaled_reg <= 32'(prod / `PSC_UNIT);
      ratio_reg  <= (pick == 32'sh0) ? 32'sh0
                    : 32'((s64 * `PSC_UNIT) / p64);
      hit_reg    <= hit_next;
    end
  end

  // Valid bits stop a start-up step being seen as a change
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hv_reg <= '0;
      for (int i = 0; i < DT; i++)
        hist_reg[i] <= 32'sh0;
    end
    else if (tick)
    begin
      hv_reg      <= {hv_reg[DT-2:0], 1'b1};
      hist_reg[0] <= scaled_reg;
      for (int i = 1; i < DT; i++)
        hist_reg[i] <= hist_reg[i-1];
    end
  end

  assign scaled = scaled_reg;
  assign ratio  = ratio_reg;
  assign hit    = hit_reg;
endmodule

`default_nettype wire

// ==== design/psc_stage.sv ====
/*
  Programmable protection stage: up to three scaled magnitudes,
  operate and release timing, blocking, condition code, registers.
  Assumes measurements and blocking on clk; plain register port.
*/
// What this block does
// - Compares one to three selected measurements independently
// - Multiplies measurement, exposes scaled magnitude
// - Unity multiplier passes raw primary value
// - Condition code normal, start, trip, blocked
// - Node behaviour code, shown in status only when enabled
// - Exposes remaining time while timing to trip
// - Exposes measured and calculated to pick-up ratios
// - Eight comparator modes, default over
// - Signed pick-up, step 0.0001, default 0.01
// - Hysteresis relative to pick-up, default 3%
// - Operate 0.04 s, release 0.06 s, 5 ms steps
// - Start only while blocking is inactive
// - Delta modes look over 20 ms
// - Blocking clears start, release then runs
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_stage #(
  parameter int TICK_CYCLES = `PSC_TICK_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic        [7:0]  reg_addr,
  input  wire logic        [31:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic             [31:0] reg_rdata,
  input  wire logic signed [31:0] meas_0,
  input  wire logic signed [31:0] meas_1,
  input  wire logic signed [31:0] meas_2,
  input  wire logic               block_in,
  output logic                    start_out,
  output logic                    trip_out,
  output logic                    blocked_out,
  output logic             [1:0]  cond_out,
  output logic                    irq
);
  import psc_pkg::*;

  // ****************************************
  // Settings
  // ****************************************
  logic        [1:0]  sel_reg;
  logic               beh_en_reg;
  psc_beh_t           beh_reg;
  logic        [15:0] op_dly_reg, rel_dly_reg;
  psc_mode_t          mode_reg [3];
  logic signed [31:0] pick_reg [3];
  logic        [31:0] hyst_reg [3];
  logic signed [31:0] mult_reg [3];
  logic [`PSC_EV_W-1:0] irq_stat_reg, irq_mask_reg, ev;

  logic signed [31:0] meas   [3];
  logic signed [31:0] scaled [3];
  logic signed [31:0] ratio  [3];
  logic        [2:0]  hit;
  logic signed [31:0] calc_ratio;
  logic        [2:0]  mag_ix;
  logic        [1:0]  mi;
  logic        [2:0]  fld;
  logic               mag_hit;

  assign mag_ix  = reg_addr[7:5];
  assign mi      = 2'(mag_ix - 3'h1);
  assign fld     = reg_addr[4:2];
  assign mag_hit = (mag_ix >= 3'h1) && (mag_ix <= 3'h3);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_reg      <= `PSC_RST_SEL;
      beh_en_reg   <= 1'b0;
      beh_reg      <= PSC_BEH_ON;
      op_dly_reg   <= `PSC_RST_OP_DLY;
      rel_dly_reg  <= `PSC_RST_REL_DLY;
      irq_mask_reg <= '0;
    end
    else if (reg_wr && reg_addr == `PSC_A_CTRL)
    begin
      sel_reg    <= reg_wdata[`PSC_CTRL_SEL];
      beh_en_reg <= reg_wdata[`PSC_CTRL_BEH_EN];
      if (reg_wdata[`PSC_CTRL_BEH] >= 3'h1 && reg_wdata[`PSC_CTRL_BEH] <= 3'h5)
        beh_reg <= psc_beh_t'(reg_wdata[`PSC_CTRL_BEH]);
    end
    else if (reg_wr && reg_addr == `PSC_A_OP_DLY)
      op_dly_reg <= reg_wdata[15:0];
    else if (reg_wr && reg_addr == `PSC_A_REL_DLY)
      rel_dly_reg <= reg_wdata[15:0];
    else if (reg_wr && reg_addr == `PSC_A_IRQ_MASK)
      irq_mask_reg <= reg_wdata[`PSC_EV_W-1:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        mode_reg[i] <= PSC_OVER;
        pick_reg[i] <= `PSC_RST_PICK;
        hyst_reg[i] <= `PSC_RST_HYST;
        mult_reg[i] <= `PSC_RST_MULT;
      end
    end
    else if (reg_wr && mag_hit)
    begin
      unique case (fld)
        `PSC_F_MODE: mode_reg[mi] <= psc_mode_t'(reg_wdata[2:0]);
        `PSC_F_PICK: pick_reg[mi] <= reg_wdata;
        `PSC_F_HYST: hyst_reg[mi] <= reg_wdata;
        `PSC_F_MULT: mult_reg[mi] <= reg_wdata;
        default:     ;
      endcase
    end
  end

  // ****************************************
  // Program cycle and magnitudes
  // ****************************************
  logic [31:0] tick_cnt_reg;
  logic        tick;

  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt_reg <= 32'h0;
    else if (tick)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  assign meas[0] = meas_0;
  assign meas[1] = meas_1;
  assign meas[2] = meas_2;

  for (genvar g = 0; g < 3; g++)
  begin : g_mag
    psc_mag_cmp u_mag (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (tick),
      .meas   (meas[g]),
      .mult   (mult_reg[g]),
      .pick   (pick_reg[g]),
      .hyst   (hyst_reg[g]),
      .mode   (mode_reg[g]),
      .scaled (scaled[g]),
      .ratio  (ratio[g]),
      .hit    (hit[g])
    );
  end

  // Calculated magnitude: the largest ratio among the selected ones
  always_comb
  begin
    calc_ratio = ratio[0];
    if (sel_reg >= 2'h2 && ratio[1] > calc_ratio)
      calc_ratio = ratio[1];
    if (sel_reg == 2'h3 && ratio[2] > calc_ratio)
      calc_ratio = ratio[2];
  end

  // ****************************************
  // Timing and condition
  // ****************************************
  psc_state_t  st_reg, st_next;
  logic [15:0] op_reg, op_next, rel_reg, rel_next;
  logic        pick_up, blk, beh_off, beh_test;

  // Selection 0 is taken as one magnitude
  assign pick_up = hit[0] && (sel_reg < 2'h2 || hit[1])
                   && (sel_reg < 2'h3 || hit[2]);
  assign beh_off  = beh_en_reg && beh_reg == PSC_BEH_OFF;
  assign beh_test = beh_en_reg && (beh_reg == PSC_BEH_TEST ||
                                   beh_reg == PSC_BEH_TEST_BL);
  assign blk = block_in || (beh_en_reg && (beh_reg == PSC_BEH_BLOCKED ||
                                           beh_reg == PSC_BEH_TEST_BL));

  always_comb
  begin
    st_next  = st_reg;
    op_next  = op_reg;
    rel_next = rel_reg;
    if (tick)
    begin
      if (beh_off)
      begin
        st_next  = PSC_ST_NORMAL;
        op_next  = op_dly_reg;
        rel_next = 16'h0;
      end
      else if (pick_up && !blk)
      begin
        rel_next = rel_dly_reg;
        if (st_reg == PSC_ST_TRIP)
          st_next = PSC_ST_TRIP;
        else if (op_reg <= 16'h1)
        begin
          st_next = PSC_ST_TRIP;
          op_next = 16'h0;
        end
        else
        begin
          st_next = PSC_ST_START;
          op_next = op_reg - 16'h1;
        end
      end
      else
      begin
        // Blocking drops start like a pick-up reset
        st_next = pick_up ? PSC_ST_BLOCKED : PSC_ST_NORMAL;
        if (rel_reg <= 16'h1)
        begin
          rel_next = 16'h0;
          op_next  = op_dly_reg;
        end
        else
          rel_next = rel_reg - 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg  <= PSC_ST_NORMAL;
      op_reg  <= `PSC_RST_OP_DLY;
      rel_reg <= 16'h0;
    end
    else
    begin
      st_reg  <= st_next;
      op_reg  <= op_next;
      rel_reg <= rel_next;
    end
  end

  always_comb
  begin
    unique case (st_reg)
      PSC_ST_NORMAL:  cond_out = 2'h0;
      PSC_ST_START:   cond_out = 2'h1;
      PSC_ST_TRIP:    cond_out = 2'h2;
      PSC_ST_BLOCKED: cond_out = 2'h3;
    endcase
  end

  // Test behaviour keeps the condition but silences start_out and trip_out; blocked_out still follows
  assign start_out   = st_reg == PSC_ST_START && !beh_test;
  assign trip_out    = st_reg == PSC_ST_TRIP && !beh_test;
  assign blocked_out = st_reg == PSC_ST_BLOCKED;

  // ****************************************
  // Events and interrupt
  // ****************************************
  assign ev = {
    st_reg == PSC_ST_BLOCKED && st_next != PSC_ST_BLOCKED,
    st_reg != PSC_ST_BLOCKED && st_next == PSC_ST_BLOCKED,
    st_reg == PSC_ST_TRIP    && st_next != PSC_ST_TRIP,
    st_reg != PSC_ST_TRIP    && st_next == PSC_ST_TRIP,
    st_reg == PSC_ST_START   && st_next != PSC_ST_START,
    st_reg != PSC_ST_START   && st_next == PSC_ST_START
  };

  // A new event wins over the clearing read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_reg <= '0;
    else if (reg_rd && reg_addr == `PSC_A_IRQ_STAT)
      irq_stat_reg <= ev;
    else
      irq_stat_reg <= irq_stat_reg | ev;
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // Read port
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0;
    if (mag_hit)
    begin
      unique case (fld)
        `PSC_F_MODE:   rd_mux = {29'h0, mode_reg[mi]};
        `PSC_F_PICK:   rd_mux = pick_reg[mi];
        `PSC_F_HYST:   rd_mux = hyst_reg[mi];
        `PSC_F_MULT:   rd_mux = mult_reg[mi];
        `PSC_F_SCALED: rd_mux = scaled[mi];
        `PSC_F_RATIO:  rd_mux = ratio[mi];
        default:       rd_mux = 32'h0;
      endcase
    end
    else
    begin
      unique case (reg_addr)
        `PSC_A_CTRL:       rd_mux = {25'h0, beh_reg, 1'b0, beh_en_reg,
                                     sel_reg};
        `PSC_A_OP_DLY:     rd_mux = {16'h0, op_dly_reg};
        `PSC_A_REL_DLY:    rd_mux = {16'h0, rel_dly_reg};
        // Behaviour code reads zero unless enabled
        `PSC_A_STATUS:     rd_mux = {25'h0,
                                     beh_en_reg ? beh_reg : 3'h0,
                                     2'h0, cond_out};
        `PSC_A_REMAIN:     rd_mux = {16'h0,
                             st_reg == PSC_ST_START ? op_reg : 16'h0};
        `PSC_A_IRQ_STAT:   rd_mux = {26'h0, irq_stat_reg};
        `PSC_A_IRQ_MASK:   rd_mux = {26'h0, irq_mask_reg};
        `PSC_A_CALC_RATIO: rd_mux = calc_ratio;
        default:           rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end
endmodule

`default_nettype wire

// ==== testbench/psc_meas_model.sv ====
/*
  Measurement subsystem and blocking matrix seen by the stage.
  Assumes the bench commands levels on clk; outputs move after an edge.
*/
`timescale 1ns/1ps
`default_nettype none

module psc_meas_model (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic signed [31:0] set_0,
  input  wire logic signed [31:0] set_1,
  input  wire logic               set_blk,
  output logic signed      [31:0] meas_0,
  output logic signed      [31:0] meas_1,
  output logic signed      [31:0] meas_2,
  output logic                    block_in
);
  // ****************************************
  // Levels, one register stage like a sampler
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      meas_0   <= 32'sh0;
      meas_1   <= 32'sh0;
      meas_2   <= 32'sh0;
      block_in <= 1'b0;
    end
    else
    begin
      meas_0   <= set_0;
      meas_1   <= set_1;
      meas_2   <= -set_0;
      block_in <= set_blk;
    end
endmodule

`default_nettype wire

// ==== testbench/psc_stage_chk.sv ====
/*
  Port checks of the stage: condition coding, blocking, timing.
  Assumes a bind into psc_stage, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module psc_stage_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        block_in,
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out,
  input wire logic [1:0]  cond_out
);
  int         gap;
  int         blk;
  logic [1:0] cond_q;

  // ****************************************
  // Helper counters, saturating
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      cond_q <= 2'h0;
      gap    <= 1000;
    end
    else
    begin
      cond_q <= cond_out;
      gap    <= (cond_out != cond_q) ? 1 : (gap < 1000 ? gap + 1 : gap);
    end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      blk <= 0;
    else
      blk <= !block_in ? 0 : (blk < 1000 ? blk + 1 : blk);

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  property p_start_code; start_out |-> cond_out == 2'h1; endproperty
  property p_trip_code; trip_out |-> cond_out == 2'h2 && !start_out; endproperty
  property p_blk_code; blocked_out == (cond_out == 2'h3); endproperty
  property p_start_free; $rose(start_out) |-> !$past(block_in); endproperty
  property p_blk_clear;
    blk > 2 * TICK_CYCLES |-> !start_out && !trip_out;
  endproperty
  property p_tick_gap; cond_out != cond_q |-> gap >= TICK_CYCLES; endproperty
  property p_trip_after; $rose(trip_out) |-> $past(cond_out) == 2'h1; endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero when idle");
  a_start_code: assert property (p_start_code)
    else $error("start with wrong condition");
  a_trip_code: assert property (p_trip_code)
    else $error("trip with wrong condition");
  a_blk_code: assert property (p_blk_code)
    else $error("blocked flag and condition differ");
  a_start_free: assert property (p_start_free)
    else $error("start rose under blocking");
  a_blk_clear: assert property (p_blk_clear)
    else $error("start or trip kept under blocking");
  a_tick_gap: assert property (p_tick_gap)
    else $error("condition changed between ticks");
  a_trip_after: assert property (p_trip_after)
    else $error("trip without start");

  c_trip: cover property (trip_out);
  c_blk_start: cover property ($fell(start_out) && blocked_out);
  c_release: cover property (cond_out == 2'h1 ##1 cond_out == 2'h0);
endmodule

`default_nettype wire

// ==== testbench/psc_stage_tb_top.sv ====
/*
  Self-checking bench of the stage with a measurement model.
  Assumes TICK_CYCLES of 10, so one tick is 500 ns.
*/
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module psc_stage_tb_top;
  localparam logic [7:0] RA [10] = '{`PSC_A_CTRL, `PSC_A_OP_DLY,
    `PSC_A_REL_DLY, `PSC_A_STATUS, 8'h20, 8'h24, 8'h28, 8'h2c,
    `PSC_A_IRQ_MASK, 8'hfc};
  localparam logic [31:0] RV [10] = '{32'h11, 32'h8, 32'hc, 32'h0,
    32'h0, 32'h64, 32'h7530, 32'h2710, 32'h0, 32'h0};
  // Idle and active levels per comparator mode
  localparam int MI [8] = '{0, 0, 5000, 5000, 1000, 1000, 0, 0};
  localparam int MA [8] = '{5000, -5000, 50, -50, 1500, 500, 500, -500};

  logic               clk;
  logic               arst_n;
  logic        [7:0]  reg_addr;
  logic        [31:0] reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [31:0] reg_rdata;
  logic signed [31:0] meas_0;
  logic signed [31:0] meas_1;
  logic signed [31:0] meas_2;
  logic signed [31:0] s0;
  logic signed [31:0] s1;
  logic               sb;
  logic               block_in;
  logic               start_out;
  logic               trip_out;
  logic               blocked_out;
  logic        [1:0]  cond_out;
  logic               irq;
  int                 checks;
  int                 miscompares;

  psc_stage #(.TICK_CYCLES(10)) psc_stage_inst (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_0(meas_0),
    .meas_1(meas_1), .meas_2(meas_2), .block_in(block_in),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .cond_out(cond_out), .irq(irq));

  psc_meas_model psc_meas_model_inst (.clk(clk), .arst_n(arst_n),
    .set_0(s0), .set_1(s1), .set_blk(sb), .meas_0(meas_0),
    .meas_1(meas_1), .meas_2(meas_2), .block_in(block_in));

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  task automatic setm(input int a, input int b, input logic k);
    @(posedge clk);
    s0 <= a;
    s1 <= b;
    sb <= k;
  endtask

  // Polls on falling edges so state edges never race the check
  task automatic wtc(input logic [1:0] v, input int n);
    int i;
    i = 0;
    @(negedge clk);
    while (cond_out !== v && i < n)
    begin
      @(negedge clk);
      i++;
    end
    `CHK(cond_out, v)
  endtask

  task automatic finish_test;
    $display("TB: checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    wr(8'hfc, 32'hffffffff);
    for (int i = 0; i < 10; i++)
      chkrd(RA[i], RV[i]);
    $display("t_reset done");
  endtask

  task automatic t_trip;
    logic [31:0] d;
    time         t0;
    wr(`PSC_A_IRQ_MASK, 32'h4);
    setm(12345, 0, 1'b0);
    wtc(2'h1, 40);
    t0 = $time;
    `CHK(irq, 1'b0)
    chkrd(`PSC_A_REMAIN, 32'h7);
    chkrd(8'h30, 32'd12345);
    chkrd(8'h34, 32'd1234500);
    chkrd(`PSC_A_CALC_RATIO, 32'd1234500);
    wtc(2'h2, 100);
    `CHK(($time - t0) / 50, 64'd70)
    `CHK(irq, 1'b1)
    rd(`PSC_A_IRQ_STAT, d);
    `CHK(d[2], 1'b1)
    `CHK(irq, 1'b0)
    wr(8'h2c, 32'd20000);
    repeat (25) @(negedge clk);
    chkrd(8'h30, 32'd24690);
    wr(8'h2c, 32'd10000);
    setm(0, 0, 1'b0);
    wtc(2'h0, 300);
    // Release must run out, else the spent operate timer trips at once
    repeat (130) @(negedge clk);
    wr(`PSC_A_REL_DLY, 32'h1);
    $display("t_trip done");
  endtask

  task automatic t_block;
    setm(5000, 0, 1'b1);
    wtc(2'h3, 60);
    `CHK(start_out, 1'b0)
    setm(5000, 0, 1'b0);
    wtc(2'h1, 40);
    setm(5000, 0, 1'b1);
    wtc(2'h3, 40);
    `CHK(start_out, 1'b0)
    setm(0, 0, 1'b0);
    wtc(2'h0, 60);
    $display("t_block done");
  endtask

  task automatic t_hyst;
    wr(`PSC_A_OP_DLY, 32'd200);
    wr(8'h24, 32'd10000);
    setm(12000, 0, 1'b0);
    wtc(2'h1, 40);
    setm(9800, 0, 1'b0);
    repeat (40) @(negedge clk);
    `CHK(cond_out, 2'h1)
    setm(9600, 0, 1'b0);
    wtc(2'h0, 60);
    wr(8'h24, 32'd100);
    $display("t_hyst done");
  endtask

  task automatic t_select;
    wr(`PSC_A_CTRL, 32'h12);
    setm(5000, 0, 1'b0);
    repeat (60) @(negedge clk);
    `CHK(cond_out, 2'h0)
    setm(5000, 5000, 1'b0);
    wtc(2'h1, 40);
    setm(0, 0, 1'b0);
    wtc(2'h0, 60);
    wr(`PSC_A_CTRL, 32'h11);
    $display("t_select done");
  endtask

  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h20, 32'(m));
      setm(MI[m], 0, 1'b0);
      repeat (80) @(negedge clk);
      wtc(2'h0, 200);
      setm(MA[m], 0, 1'b0);
      wtc(2'h1, 60);
    end
    wr(8'h20, 32'h0);
    setm(0, 0, 1'b0);
    wtc(2'h0, 200);
    $display("t_modes done");
  endtask

  task automatic t_beh;
    logic [31:0] d;
    for (int b = 1; b < 6; b++)
    begin
      wr(`PSC_A_CTRL, 32'h5 | (32'(b) << 4));
      rd(`PSC_A_STATUS, d);
      `CHK(d[6:4], 3'(b))
    end
    wr(`PSC_A_CTRL, 32'h65);
    rd(`PSC_A_STATUS, d);
    `CHK(d[6:4], 3'h5)
    wr(`PSC_A_CTRL, 32'h11);
    rd(`PSC_A_STATUS, d);
    `CHK(d[6:4], 3'h0)
    $display("t_beh done");
  endtask

  // ****************************************
  // Clock, reset, sequence, watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    checks      = 0;
    miscompares = 0;
    arst_n      = 1'b0;
    reg_addr    = 8'h0;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    s0          = 0;
    s1          = 0;
    sb          = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_trip;
    t_block;
    t_hyst;
    t_select;
    t_modes;
    t_beh;
    finish_test;
  end

  // Whole run needs about 2000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    finish_test;
  end
endmodule

bind psc_stage psc_stage_chk #(.TICK_CYCLES(TICK_CYCLES)) psc_stage_chk_inst (
  .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
  .blocked_out(blocked_out), .cond_out(cond_out));

`default_nettype wire
